// ---- rtl/drc_pkg.sv ----
// Package for the 4096 x 1 strobe memory controller: timing and carriers
package drc_pkg;
  // Clock period in ps and derived cycle counts (125 MHz)
  localparam int CLK_PS = 8000;
  localparam int T_RAS_NS = 150;  // Row strobe low time, least
  localparam int T_RP_NS = 120;  // Row strobe precharge, least
  localparam int T_RCD_NS = 25;  // Row to column strobe delay, least
  localparam int T_CAS_NS = 135;  // Column strobe low time, least
  localparam int T_CWD_NS = 80;  // Column strobe to late write delay, least
  localparam int T_WP_NS = 55;  // Write strobe low time, least
  localparam int T_CAC_NS = 135;  // Access time from column strobe
  localparam int T_RFSH_US = 2000;  // Refresh period
  localparam int T_RAS_CYC = (T_RAS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int T_RP_CYC = (T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int T_RCD_CYC = (T_RCD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int T_CAS_CYC = (T_CAS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int T_CWD_CYC = (T_CWD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int T_WP_CYC = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int T_CAC_CYC = (T_CAC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int ROWS = 64;
  // Worst wait for an access in flight before a due refresh can start
  localparam int REF_SLACK_CYC = 64;
  // Refresh interval per row, shortened by that wait so all rows fit in 2 ms
  localparam int REF_STEP_CYC =
    (T_RFSH_US * 1000000 / CLK_PS - REF_SLACK_CYC) / ROWS;
  localparam int POWER_UP_CYCLES = 8;
  localparam int ADDR_W = 12;
  localparam int HALF_W = 6;
  localparam int CNT_W = 16;

  // User request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic late_write;  // Delayed write: read then write in one cycle
    logic deselect;  // Chip select held high for the access
    logic wdata;
  } drc_req_s;

  // Memory pins driven by the controller
  typedef struct packed {
    logic row_strobe_n;
    logic column_strobe_n;
    logic chip_select_n;
    logic write_enable_n;
    logic data_in;
    logic [HALF_W-1:0] multiplexed_address_inputs;
  } drc_pins_s;
endpackage

// ---- rtl/drc_ctrl.sv ----
// Controller that drives a 4096 x 1 multiplexed-address dynamic memory
// Rules of the memory this block drives
// RULE_01: Row half of the 12-bit address goes out first, latched on row fall.
// RULE_02: Column half and chip select stand valid at the column strobe fall.
// RULE_03: Device latches write data on the later of write or column fall.
// RULE_04: Early write drops write enable before the column strobe falls; here both change on the same clock edge.
// RULE_05: Delayed write drops write enable only after the column strobe fell.
// RULE_06: Chip select high at column fall makes the device ignore writes.
// RULE_07: Reads hold write enable high the whole time column strobe is low.
// RULE_08: Device floats data out on every column strobe fall.
// RULE_09: Selected read or delayed write drives stored bit by access time.
// RULE_10: Selected early write drives the written bit by access time.
// RULE_11: Data out holds until the next column fall, row-only cycles aside.
// RULE_12: Column strobe without row strobe keeps data out floating.
// RULE_13: Deselected normal cycle keeps data out floating.
// RULE_14: Every one of 64 rows gets a cycle within each 2 ms.
// RULE_15: Refresh uses row-only cycles, so no cell is written.
// RULE_16: Long row-only runs may float data out until a column cycle.
// RULE_17: Refresh keeps column strobe high so shared outputs never fight.
// RULE_18: Row strobe goes only to selected devices for power saving; here it also falls for deselected accesses.
// RULE_19: Page mode holds row strobe low across several column cycles.
// RULE_20: In page mode chip select acts on each column cycle alone.
// RULE_21: At least 8 refresh cycles run before any user access.
// RULE_22: Write enable timing meets either early or delayed write limits.
// RULE_23: A 6-bit refresh row counter advances after each refresh.
`timescale 1ns/10ps
`default_nettype none
module drc_ctrl
  import drc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // User request port
  input wire logic req_valid,
  input wire drc_req_s req,
  input wire logic req_page,  // Keep row open for a following same-row request
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_data,
  output logic init_done,
  // Memory pins
  output drc_pins_s mem,
  input wire logic mem_data_out,
  input wire logic mem_data_out_en
);
  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_ROW, ST_COL, ST_WR, ST_CAS_UP, ST_REF
  } drc_state_e;

  drc_state_e state_reg;
  logic [CNT_W-1:0] timer_reg;
  logic [CNT_W-1:0] ref_timer_reg;
  logic ref_due_reg;
  logic [HALF_W-1:0] ref_row_reg;
  logic [3:0] init_cnt_reg;
  drc_req_s cur_reg;
  logic page_reg;

  // Cycle count as a sized timer value
  function automatic logic [CNT_W-1:0] cyc(input int n);
    return CNT_W'(n);
  endfunction

  wire logic timer_done = (timer_reg == '0);
  wire logic same_row = (req.addr[ADDR_W-1:HALF_W] ==
                         cur_reg.addr[ADDR_W-1:HALF_W]);

  // Refresh pacing; a pending refresh survives until its cycle ends
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ref_timer_reg <= '0;
      ref_due_reg <= 1'b0;
    end else begin
      if (ref_timer_reg == cyc(REF_STEP_CYC - 1)) begin
        ref_timer_reg <= '0;
        ref_due_reg <= 1'b1;  // see RULE_14
      end else begin
        ref_timer_reg <= ref_timer_reg + 1'b1;
        if (state_reg == ST_REF && timer_done)
          ref_due_reg <= 1'b0;
      end
    end
  end

  // Refresh row counter and power-up count
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ref_row_reg <= '0;
      init_cnt_reg <= '0;
      init_done <= 1'b0;
    end else if (state_reg == ST_REF && timer_done) begin
      ref_row_reg <= ref_row_reg + 1'b1;  // see RULE_23
      if (init_cnt_reg != 4'(POWER_UP_CYCLES))
        init_cnt_reg <= init_cnt_reg + 1'b1;
      if (init_cnt_reg == 4'(POWER_UP_CYCLES - 1))
        init_done <= 1'b1;  // see RULE_21
    end
  end

  // Main sequencer and pins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= ST_INIT;
      timer_reg <= '0;
      cur_reg <= '0;
      page_reg <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 1'b0;
      mem <= '{row_strobe_n: 1'b1, column_strobe_n: 1'b1,
               chip_select_n: 1'b1, write_enable_n: 1'b1,
               data_in: 1'b0, multiplexed_address_inputs: '0};
    end else begin
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      if (!timer_done)
        timer_reg <= timer_reg - 1'b1;
      unique case (state_reg)
        ST_INIT, ST_IDLE: begin
          if (timer_done && (ref_due_reg || state_reg == ST_INIT)) begin
            // Row-only refresh keeps column strobe high: see RULE_15 RULE_17
            mem.multiplexed_address_inputs <= ref_row_reg;
            mem.row_strobe_n <= 1'b0;
            timer_reg <= cyc(T_RAS_CYC - 1);
            state_reg <= ST_REF;
          end else if (timer_done && init_done && req_valid) begin
            req_ready <= 1'b1;
            cur_reg <= req;
            // Row half first: see RULE_01
            mem.multiplexed_address_inputs <= req.addr[ADDR_W-1:HALF_W];
            // Row strobe drops only for a taken access; see RULE_18
            mem.row_strobe_n <= 1'b0;
            timer_reg <= cyc(T_RCD_CYC - 1);
            state_reg <= ST_ROW;
          end
        end
        ST_REF: if (timer_done) begin
          mem.row_strobe_n <= 1'b1;
          timer_reg <= cyc(T_RP_CYC - 1);
          state_reg <= init_done ? ST_IDLE : ST_INIT;
        end
        ST_ROW: if (timer_done) begin
          // Column, select and early write change in the same cycle as the fall
          mem.multiplexed_address_inputs <= cur_reg.addr[HALF_W-1:0];
          mem.chip_select_n <= cur_reg.deselect;  // see RULE_02 RULE_20
          mem.data_in <= cur_reg.wdata;
          // Early write: enable low with the column fall; see RULE_04
          mem.write_enable_n <= !(cur_reg.write && !cur_reg.late_write);
          mem.column_strobe_n <= 1'b0;
          timer_reg <= cyc(T_CWD_CYC - 1);
          state_reg <= ST_COL;
        end
        ST_COL: if (timer_done) begin
          if (cur_reg.write && cur_reg.late_write) begin
            mem.write_enable_n <= 1'b0;  // see RULE_05 RULE_22
            timer_reg <= cyc(T_WP_CYC - 1);
            state_reg <= ST_WR;
          end else begin
            // Read keeps enable high while column is low; see RULE_07
            timer_reg <= cyc(T_CAC_CYC - T_CWD_CYC);
            state_reg <= ST_WR;
          end
        end
        ST_WR: if (timer_done) begin
          // Sample data out after access time
          rsp_valid <= 1'b1;
          rsp_data <= mem_data_out_en ? mem_data_out : 1'b0;
          mem.column_strobe_n <= 1'b1;
          mem.write_enable_n <= 1'b1;
          mem.chip_select_n <= 1'b1;
          timer_reg <= cyc(T_RP_CYC - 1);
          page_reg <= req_page;
          state_reg <= ST_CAS_UP;
        end
        ST_CAS_UP: if (timer_done) begin
          // Page mode keeps row open for a same-row request; see RULE_19
          if (page_reg && req_valid && same_row && !ref_due_reg) begin
            req_ready <= 1'b1;
            cur_reg <= req;
            state_reg <= ST_ROW;
          end else begin
            mem.row_strobe_n <= 1'b1;
            timer_reg <= cyc(T_RP_CYC - 1);
            state_reg <= ST_IDLE;
          end
        end
        // The one unused state code falls back to idle
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Row strobe stays low for at least 8 cycles after each fall
  property p_ras_min;
    @(posedge core_clk) disable iff (reset)
      $fell(mem.row_strobe_n) |-> mem.row_strobe_n == 1'b0 [*8];
  endproperty
  a_ras_min: assert property (p_ras_min)  // see RULE_14
    else $error("row strobe too short");

  // Column strobe never falls without the row strobe low
  property p_cas_in_row;
    @(posedge core_clk) disable iff (reset)
      $fell(mem.column_strobe_n) |-> !mem.row_strobe_n;
  endproperty
  a_cas_in_row: assert property (p_cas_in_row)  // see RULE_01
    else $error("column without row");

  // Refresh cycles keep column strobe high
  property p_ref_no_cas;
    @(posedge core_clk) disable iff (reset)
      state_reg == ST_REF |-> mem.column_strobe_n;
  endproperty
  a_ref_no_cas: assert property (p_ref_no_cas)  // see RULE_17
    else $error("column in refresh");

  // Reads hold write enable high while column strobe is low
  property p_read_we_high;
    @(posedge core_clk) disable iff (reset)
      (!mem.column_strobe_n && !cur_reg.write) |-> mem.write_enable_n;
  endproperty
  a_read_we_high: assert property (p_read_we_high)  // see RULE_07
    else $error("write in read");

  // Late write falls only after the column strobe has been low
  property p_late_we;
    @(posedge core_clk) disable iff (reset)
      ($fell(mem.write_enable_n) && cur_reg.late_write)
        |-> $past(!mem.column_strobe_n, 1);
  endproperty
  a_late_we: assert property (p_late_we)  // see RULE_05
    else $error("late write too early");

  // No user access before power-up refreshes
  property p_init;
    @(posedge core_clk) disable iff (reset)
      req_ready |-> init_done;
  endproperty
  a_init: assert property (p_init)  // see RULE_21
    else $error("access before init");
endmodule  // drc_ctrl
`default_nettype wire

// ---- verif/drc_mem_model.sv ----
// Behavioural 4096 x 1 strobe memory seen from the controller's pins
`timescale 1ns/10ps
`default_nettype none
module drc_mem_model
  import drc_pkg::*;
(
  // Pins from the controller
  input wire drc_pins_s mem,
  // Data out and its drive flag
  output logic data_out,
  output logic data_out_en
);
  logic cells [0:4095];
  logic [HALF_W-1:0] row_reg;
  logic [ADDR_W-1:0] cell_addr;
  logic sel_reg = 1'b0;
  logic out_reg = 1'b0;
  initial data_out_en = 1'b0;
  // A floating line shows the inverse of the last bit, never a stale copy
  assign data_out = data_out_en ? out_reg : ~out_reg;
  // Row half latched on the row strobe fall
  // Row-only cycles leave data out alone; this model never lets it decay
  always @(negedge mem.row_strobe_n)
    row_reg = mem.multiplexed_address_inputs;
  // Column fall floats the output, then decides the cycle
  always @(negedge mem.column_strobe_n) begin
    data_out_en = 1'b0;
    cell_addr = {row_reg,
      mem.multiplexed_address_inputs};
    sel_reg = !mem.chip_select_n && !mem.row_strobe_n;
    if (sel_reg && !mem.write_enable_n)
      cells[cell_addr] = mem.data_in;
    if (sel_reg) begin
      out_reg <= #(T_CAC_NS) cells[cell_addr];
      data_out_en <= #(T_CAC_NS) 1'b1;
    end
  end
  // Clearing here keeps a same-instant write fall from using a stale cell
  always @(posedge mem.column_strobe_n) sel_reg = 1'b0;
  // Late write strobes data in on the write fall
  always @(negedge mem.write_enable_n)
    if (sel_reg) cells[cell_addr] = mem.data_in;
endmodule // drc_mem_model
`default_nettype wire

// ---- verif/drc_ctrl_bench.sv ----
// Self-checking bench: corner and random accesses against the memory model
`timescale 1ns/10ps
`default_nettype none
module drc_ctrl_bench
  import drc_pkg::*;
;
  logic core_clk, reset, req_valid, req_page, dout, dout_en, pg, last_page;
  logic req_ready, rsp_valid, rsp_data, init_done, cur_read;
  drc_req_s req, r;
  drc_pins_s mem;
  logic ref_bit [0:4095];
  bit known [0:4095];
  logic [31:0] seed = 32'h859b;
  logic [5:0] last_row;
  int fail_count = 0;
  int comparisons = 0;
  int rf_count = 0;
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  drc_ctrl i_dut (.core_clk(core_clk), .reset(reset), .req_valid(req_valid),
    .req(req), .req_page(req_page), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .init_done(init_done),
    .mem(mem), .mem_data_out(dout), .mem_data_out_en(dout_en));
  drc_mem_model i_mem (.mem(mem), .data_out(dout), .data_out_en(dout_en));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Deselected cycles read back as 0 because the line floats
  function automatic logic exp_rsp(input drc_req_s q, input logic old);
    if (q.deselect) return 1'b0;
    if (q.write && !q.late_write) return q.wdata;
    return old;
  endfunction
  task automatic check(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One request held until taken, then wait for its answer
  task automatic access(input drc_req_s q, input logic p);
    int n;
    logic old;
    bit chk;
    old = ref_bit[q.addr];
    chk = q.deselect || (q.write && !q.late_write) || known[q.addr];
    @(posedge core_clk) #1;
    req = q;
    req_page = p;
    req_valid = 1'b1;
    cur_read = !q.write;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    check(init_done, 1'b1);
    check(rf_count >= 8, 1'b1);
    @(posedge core_clk) #1;
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 3200) begin
      @(negedge core_clk);
      n++;
    end
    check(n < 3200, 1'b1);
    if (chk) check(rsp_data, exp_rsp(q, old));
    if (q.write && !q.deselect) begin
      ref_bit[q.addr] = q.wdata;
      known[q.addr] = 1'b1;
    end
    cur_read = 1'b0;
  endtask
  // Power-up cycles are counted until the controller reports ready
  always @(negedge mem.row_strobe_n) if (init_done !== 1'b1) rf_count++;
  // Reads keep the write strobe high while the column strobe is low
  always @(negedge core_clk)
    if (cur_read && !mem.column_strobe_n)
      check(mem.write_enable_n, 1'b1);
  initial begin
    #(20000 * 8);
    fail_count++;
    give_verdict();
  end
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req_page = 1'b0;
    req = '0;
    cur_read = 1'b0;
    last_page = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 reset = 1'b0;
    // Array ends, deselected write, late write and a page run
    access('{12'h000, 1'b1, 1'b0, 1'b0, 1'b1}, 1'b0);
    access('{12'hfff, 1'b1, 1'b1, 1'b0, 1'b0}, 1'b0);
    access('{12'h000, 1'b1, 1'b0, 1'b1, 1'b0}, 1'b0);
    access('{12'h000, 1'b0, 1'b0, 1'b0, 1'b0}, 1'b0);
    access('{12'h000, 1'b1, 1'b1, 1'b0, 1'b0}, 1'b0);
    access('{12'hfff, 1'b0, 1'b0, 1'b1, 1'b0}, 1'b0);
    access('{12'h040, 1'b1, 1'b0, 1'b1, 1'b1}, 1'b1);
    access('{12'h041, 1'b1, 1'b0, 1'b0, 1'b1}, 1'b1);
    access('{12'h041, 1'b0, 1'b0, 1'b0, 1'b0}, 1'b0);
    // Random traffic over a few rows so reads hit written cells
    for (int i = 0; i < 150; i++) begin
      seed = xorshift(seed);
      r.addr = {seed[8:6], 3'h0, seed[2:0], 3'h5};
      if (last_page) r.addr[11:6] = last_row;
      r.write = seed[12];
      r.late_write = seed[12] & seed[13];
      r.deselect = seed[15:14] == 2'h0;
      r.wdata = seed[16];
      pg = seed[17];
      access(r, pg);
      last_page = pg;
      last_row = r.addr[11:6];
    end
    give_verdict();
  end
endmodule // drc_ctrl_bench
`default_nettype wire
